// ===== pkg/usc_regs_defs.vh
`ifndef USC_REGS_DEFS_VH
`define USC_REGS_DEFS_VH
// Register offsets (byte addresses on the 8-bit space)
`define USC_ADDR_W 8
`define USC_OFS_CTRL1 8'h05
`define USC_OFS_IMASK 8'h06
`define USC_OFS_DEVADDR 8'h07
`define USC_OFS_IFLAGS 8'h0D
`define USC_OFS_BUFSEL 8'h0E
`define USC_OFS_CTRL2 8'h0F
`define USC_OFS_FRAME_LO 8'h15
`define USC_OFS_FRAME_HI 8'h16
`define USC_OFS_DMA_LO 8'h35
`define USC_OFS_DMA_HI 8'h36
// Control register 1 fields
`define USC_C1_RSVD 7
`define USC_C1_STBY 6
`define USC_C1_LOWSPD 5
`define USC_C1_LF_HI 4
`define USC_C1_LF_LO 3
`define USC_C1_DMADIR 2
`define USC_C1_DMAEN 1
`define USC_C1_USBEN 0
// Interrupt bits
`define USC_IRQ_DMA_BUSY 7
`define USC_IRQ_EVT_W 7
// Line force codes
`define USC_LF_NORMAL 2'h0
`define USC_LF_SE0 2'h1
`define USC_LF_K 2'h2
`define USC_LF_J 2'h3
// Reset values
`define USC_RST_BYTE 8'h00
`define USC_RST_CTRL1 8'h00
`endif

// ===== rtl/usc_ctrl_regs.v
// Functional notes
// - Ten byte registers decoded at fixed offsets
// - Control bit 6 puts transceiver in standby
// - Suspend when standby set and enable clear
// - Control bit 5 selects low speed
// - Bits 4:3 force normal, SE0, K, J
// - Line force bits clear at reset
// - Control bit 2 sets DMA direction
// - DMA enable; start on high count write
// - Control bit 0 gates USB transfers
// - USB enable clears at reset
// - Interrupt request only for enabled events
// - Enable writes leave status flags untouched
// - Mask bits 6..4: reset, SOF, DMA done
// - Mask bits 3..0: endpoint 3..0 done
// - Mask bit 7 reads DMA in progress
// - Status flags clear on written one
// - DMA busy bit never raises interrupt
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/100ps
`include "usc_regs_defs.vh"
module usc_ctrl_regs #(
  parameter DW = 8
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Avalon-MM slave
  input wire [`USC_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [DW-1:0] avs_writedata,
  output reg [DW-1:0] avs_readdata,
  output reg avs_waitrequest,
  // Event pulses from the serial engine and DMA logic
  input wire [`USC_IRQ_EVT_W-1:0] evt_pulse,
  input wire dma_complete,
  // Frame number and buffer select state from the engine
  input wire [DW-1:0] frame_lo_in,
  input wire [DW-1:0] frame_hi_in,
  input wire [DW-1:0] buf_sel_in,
  // Controls to the rest of the device
  output reg transceiver_standby,
  output reg suspend_mode,
  output reg low_speed_select,
  output reg line_force_hi_bit,
  output reg line_force_lo_bit,
  output reg force_dp_r,
  output reg force_dm_r,
  output reg force_active_r,
  output reg dma_read_dir,
  output reg dma_enable,
  output reg dma_start,
  output reg dma_busy,
  output reg usb_enable,
  output reg [DW-1:0] device_bus_address,
  output reg [DW-1:0] usb_control_two,
  output reg [DW-1:0] dma_length,
  output reg [2*DW-1:0] dma_total_count,
  output reg interrupt_request_out
);

  // ==========================================
  // Register storage
  reg [DW-1:0] ctrl1_r;
  reg [DW-2:0] imask_r;
  reg [DW-2:0] iflags_r;
  reg [DW-1:0] dma_lo_r;
  reg [DW-1:0] dma_hi_r;
  reg busy_r;
  reg ack_r;
  wire req = (avs_read | avs_write) & ~ack_r;
  wire wr = avs_write & ~ack_r;
  wire rd = avs_read & ~ack_r;
  wire [DW-2:0] iflags_nxt;
  wire [DW-1:0] ctrl1_wr = {1'b0, avs_writedata[DW-2:0]};

  // ==========================================
  // Address decode, one select per register
  reg sel_ctrl1;
  reg sel_imask;
  reg sel_devaddr;
  reg sel_iflags;
  reg sel_bufsel;
  reg sel_ctrl2;
  reg sel_frame_lo;
  reg sel_frame_hi;
  reg sel_dma_lo;
  reg sel_dma_hi;
  always @* begin
    sel_ctrl1 = 1'b0;
    sel_imask = 1'b0;
    sel_devaddr = 1'b0;
    sel_iflags = 1'b0;
    sel_bufsel = 1'b0;
    sel_ctrl2 = 1'b0;
    sel_frame_lo = 1'b0;
    sel_frame_hi = 1'b0;
    sel_dma_lo = 1'b0;
    sel_dma_hi = 1'b0;
    if (avs_address == `USC_OFS_CTRL1) begin
      sel_ctrl1 = 1'b1;
    end else if (avs_address == `USC_OFS_IMASK) begin
      sel_imask = 1'b1;
    end else if (avs_address == `USC_OFS_DEVADDR) begin
      sel_devaddr = 1'b1;
    end else if (avs_address == `USC_OFS_IFLAGS) begin
      sel_iflags = 1'b1;
    end else if (avs_address == `USC_OFS_BUFSEL) begin
      sel_bufsel = 1'b1;
    end else if (avs_address == `USC_OFS_CTRL2) begin
      sel_ctrl2 = 1'b1;
    end else if (avs_address == `USC_OFS_FRAME_LO) begin
      sel_frame_lo = 1'b1;
    end else if (avs_address == `USC_OFS_FRAME_HI) begin
      sel_frame_hi = 1'b1;
    end else if (avs_address == `USC_OFS_DMA_LO) begin
      sel_dma_lo = 1'b1;
    end else if (avs_address == `USC_OFS_DMA_HI) begin
      sel_dma_hi = 1'b1;
    end
  end

  // ==========================================
  // Write strobes
  wire wr_ctrl1 = wr & sel_ctrl1;
  wire wr_imask = wr & sel_imask;
  wire wr_devaddr = wr & sel_devaddr;
  wire wr_iflags = wr & sel_iflags;
  wire wr_ctrl2 = wr & sel_ctrl2;
  wire wr_dma_lo = wr & sel_dma_lo;
  wire wr_dma_hi = wr & sel_dma_hi;

  // ==========================================
  // Event flags: a new event wins over a same-cycle clear
  genvar gi;
  generate
    for (gi = 0; gi < DW-1; gi = gi + 1) begin : g_flag
      wire clr = wr_iflags & avs_writedata[gi];
      assign iflags_nxt[gi] = evt_pulse[gi] | (iflags_r[gi] & ~clr);
    end
  endgenerate

  // ==========================================
  // Bus handshake: one wait cycle, answer on second cycle
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_r <= req;
      avs_waitrequest <= ~req;
    end
  end

  // ==========================================
  // Control register 1
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl1_r <= `USC_RST_CTRL1;
    end else if (wr_ctrl1) begin
      ctrl1_r <= ctrl1_wr;
    end
  end

  // ==========================================
  // Interrupt mask, never touches the flags
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      imask_r <= {(DW-1){1'b0}};
    end else if (wr_imask) begin
      imask_r <= avs_writedata[DW-2:0];
    end
  end

  // ==========================================
  // Event flags
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      iflags_r <= {(DW-1){1'b0}};
    end else begin
      iflags_r <= iflags_nxt;
    end
  end

  // ==========================================
  // Device bus address
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      device_bus_address <= `USC_RST_BYTE;
    end else if (wr_devaddr) begin
      device_bus_address <= avs_writedata;
    end
  end

  // ==========================================
  // Control register 2
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      usb_control_two <= `USC_RST_BYTE;
    end else if (wr_ctrl2) begin
      usb_control_two <= avs_writedata;
    end
  end

  // ==========================================
  // DMA count low byte
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dma_lo_r <= `USC_RST_BYTE;
    end else if (wr_dma_lo) begin
      dma_lo_r <= avs_writedata;
    end
  end

  // ==========================================
  // DMA count high byte
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dma_hi_r <= `USC_RST_BYTE;
    end else if (wr_dma_hi) begin
      dma_hi_r <= avs_writedata;
    end
  end

  // ==========================================
  // DMA launch on the high count write; a launch beats a same-cycle completion
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
      dma_start <= 1'b0;
    end else begin
      dma_start <= 1'b0;
      if (wr_dma_hi && ctrl1_r[`USC_C1_DMAEN]) begin
        dma_start <= 1'b1;
        busy_r <= 1'b1;
      end else if (dma_complete) begin
        busy_r <= 1'b0;
      end
    end
  end

  // ==========================================
  // Read data, registered on the answer cycle
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= `USC_RST_BYTE;
    end else if (rd) begin
      if (sel_ctrl1) begin
        avs_readdata <= ctrl1_r;
      end else if (sel_imask) begin
        avs_readdata <= {busy_r, imask_r};
      end else if (sel_devaddr) begin
        avs_readdata <= device_bus_address;
      end else if (sel_iflags) begin
        avs_readdata <= {busy_r, iflags_r};
      end else if (sel_bufsel) begin
        avs_readdata <= buf_sel_in;
      end else if (sel_ctrl2) begin
        avs_readdata <= usb_control_two;
      end else if (sel_frame_lo) begin
        avs_readdata <= frame_lo_in;
      end else if (sel_frame_hi) begin
        avs_readdata <= frame_hi_in;
      end else if (sel_dma_lo) begin
        avs_readdata <= dma_lo_r;
      end else if (sel_dma_hi) begin
        avs_readdata <= dma_hi_r;
      end else begin
        avs_readdata <= `USC_RST_BYTE;
      end
    end
  end

  // ==========================================
  // Transceiver standby, suspend and transfer enable
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      transceiver_standby <= 1'b0;
      suspend_mode <= 1'b0;
      usb_enable <= 1'b0;
    end else begin
      transceiver_standby <= ctrl1_r[`USC_C1_STBY];
      suspend_mode <= ctrl1_r[`USC_C1_STBY] & ~ctrl1_r[`USC_C1_USBEN];
      usb_enable <= ctrl1_r[`USC_C1_USBEN];
    end
  end

  // ==========================================
  // Speed select
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_speed_select <= 1'b0;
    end else begin
      low_speed_select <= ctrl1_r[`USC_C1_LOWSPD];
    end
  end

  // ==========================================
  // Line force
  wire [1:0] lf = {ctrl1_r[`USC_C1_LF_HI], ctrl1_r[`USC_C1_LF_LO]};
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_force_hi_bit <= 1'b0;
      line_force_lo_bit <= 1'b0;
      force_dp_r <= 1'b0;
      force_dm_r <= 1'b0;
      force_active_r <= 1'b0;
    end else begin
      line_force_hi_bit <= ctrl1_r[`USC_C1_LF_HI];
      line_force_lo_bit <= ctrl1_r[`USC_C1_LF_LO];
      force_active_r <= (lf != `USC_LF_NORMAL);
      force_dp_r <= (lf == `USC_LF_J);
      force_dm_r <= (lf == `USC_LF_K);
    end
  end

  // ==========================================
  // DMA controls
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dma_read_dir <= 1'b0;
      dma_enable <= 1'b0;
      dma_busy <= 1'b0;
      dma_length <= `USC_RST_BYTE;
      dma_total_count <= {(2*DW){1'b0}};
    end else begin
      dma_read_dir <= ctrl1_r[`USC_C1_DMADIR];
      dma_enable <= ctrl1_r[`USC_C1_DMAEN];
      dma_busy <= busy_r;
      dma_length <= dma_lo_r;
      dma_total_count <= {dma_hi_r, dma_lo_r};
    end
  end

  // ==========================================
  // Interrupt request
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      interrupt_request_out <= 1'b0;
    end else begin
      interrupt_request_out <= |(iflags_r & imask_r);
    end
  end

endmodule

// ===== verification/usc_props.sv
`timescale 1ns/100ps
module usc_props (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Bus
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [7:0] avs_writedata,
  input wire avs_waitrequest,
  // Controls
  input wire transceiver_standby,
  input wire suspend_mode,
  input wire line_force_hi_bit,
  input wire line_force_lo_bit,
  input wire force_dp_r,
  input wire force_dm_r,
  input wire force_active_r,
  input wire usb_enable,
  input wire dma_start,
  input wire dma_busy
);
  // ==========
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_c1wr; avs_write && !avs_waitrequest && avs_address == 8'h05; endsequence
  property p_ctl; s_c1wr |=> usb_enable == $past(avs_writedata[0])
    && transceiver_standby == $past(avs_writedata[6]); endproperty
  a_ctl: assert property (p_ctl) else $error("ctrl write not applied");
  property p_susp; suspend_mode == (transceiver_standby && !usb_enable); endproperty
  a_susp: assert property (p_susp) else $error("suspend wrong");
  property p_fj; force_dp_r == (line_force_hi_bit && line_force_lo_bit); endproperty
  a_fj: assert property (p_fj) else $error("J force wrong");
  property p_fk; force_dm_r == (line_force_hi_bit && !line_force_lo_bit); endproperty
  a_fk: assert property (p_fk) else $error("K force wrong");
  property p_fa; force_active_r == (line_force_hi_bit || line_force_lo_bit); endproperty
  a_fa: assert property (p_fa) else $error("force active wrong");
  property p_ans; s_req |=> !avs_waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("answer too long");
  property p_start; dma_start |=> dma_busy; endproperty
  a_start: assert property (p_start) else $error("start without busy");
  property p_srcw; dma_start |-> $past(avs_write && avs_waitrequest && avs_address == 8'h36);
  endproperty
  a_srcw: assert property (p_srcw) else $error("DMA start without count write");
endmodule
bind usc_ctrl_regs usc_props u_props (.*);

// ===== verification/usc_evt_src.sv
`timescale 1ns/100ps
module usc_evt_src (
  // Clock
  input wire clk,
  // Events
  output reg [6:0] evt_pulse,
  output reg dma_complete
);
  initial {dma_complete, evt_pulse} = 8'h00;
  // One-cycle pulse on every set bit
  task fire(input [7:0] e);
    @(posedge clk);
    {dma_complete, evt_pulse} <= e;
    @(posedge clk);
    {dma_complete, evt_pulse} <= 8'h00;
  endtask
endmodule

// ===== verification/usc_ctrl_regs_tb.sv
`timescale 1ns/100ps
module usc_ctrl_regs_tb;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [7:0] avs_address = 8'h00;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [7:0] avs_writedata = 8'h00;
  reg [7:0] frame_lo_in = 8'hA5;
  reg [7:0] frame_hi_in = 8'h5A;
  reg [7:0] buf_sel_in = 8'h03;
  reg [7:0] rd;
  wire [7:0] avs_readdata;
  wire avs_waitrequest, transceiver_standby, suspend_mode, low_speed_select;
  wire line_force_hi_bit, line_force_lo_bit, force_dp_r, force_dm_r, force_active_r;
  wire dma_read_dir, dma_enable, dma_start, dma_busy, usb_enable;
  wire interrupt_request_out, dma_complete;
  wire [6:0] evt_pulse;
  wire [15:0] dma_total_count;
  wire [7:0] device_bus_address, usb_control_two, dma_length;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int starts = 0;
  usc_ctrl_regs DUT (.*);
  usc_evt_src EVS (.clk(clk), .evt_pulse(evt_pulse), .dma_complete(dma_complete));
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (dma_start) begin
      starts <= starts + 1;
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      bad_count++;
      results;
    end
  end
  // ==========
  // Tasks
  task results;
    $display("bad %0d of %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string n, input [16:0] s, input [16:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task bus(input w, input [7:0] a, input [7:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task rdc(input string n, input [7:0] a, input [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(n, rd, e);
  endtask
  task wt(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // ==========
  // Tests
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk("rst", {usb_enable, force_active_r, line_force_hi_bit}, 0);
    rdc("c1rst", 8'h05, 8'h00);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h05, 8'(8'h40 + i * 8));
      wt(1);
      chk("force", {suspend_mode, force_active_r, force_dp_r, force_dm_r, line_force_hi_bit,
        line_force_lo_bit}, {1'b1, i != 0, i == 3, i == 2, 2'(i)});
      rdc("c1", 8'h05, 8'(8'h40 + i * 8));
    end
    bus(1'b1, 8'h05, 8'h67);
    wt(1);
    chk("c1out", {transceiver_standby, suspend_mode, low_speed_select, dma_read_dir,
      dma_enable, usb_enable}, 6'h2F);
    bus(1'b1, 8'h06, 8'h01);
    EVS.fire(8'h03);
    wt(2);
    chk("irq", interrupt_request_out, 1);
    rdc("flags", 8'h0D, 8'h03);
    bus(1'b1, 8'h06, 8'h70);
    wt(2);
    chk("irqm", interrupt_request_out, 0);
    rdc("fkeep", 8'h0D, 8'h03);
    EVS.fire(8'h70);
    wt(2);
    chk("irqh", interrupt_request_out, 1);
    bus(1'b1, 8'h0D, 8'h71);
    wt(2);
    chk("irqc", interrupt_request_out, 0);
    rdc("w1c", 8'h0D, 8'h02);
    bus(1'b1, 8'h35, 8'h34);
    bus(1'b1, 8'h36, 8'h12);
    wt(1);
    chk("dma", {dma_busy, dma_total_count}, 17'h11234);
    chk("dlen", dma_length, 8'h34);
    chk("start", starts, 1);
    rdc("dhi", 8'h36, 8'h12);
    rdc("busy", 8'h06, 8'hF0);
    bus(1'b1, 8'h0D, 8'h02);
    bus(1'b1, 8'h06, 8'h7F);
    EVS.fire(8'h80);
    wt(2);
    chk("irqd", {interrupt_request_out, dma_busy}, 0);
    rdc("idle", 8'h06, 8'h7F);
    rdc("unmap", 8'h40, 8'h00);
    rdc("frame", 8'h15, 8'hA5);
    bus(1'b1, 8'h07, 8'h2C);
    bus(1'b1, 8'h0F, 8'h80);
    wt(1);
    chk("addr", {device_bus_address, usb_control_two}, 16'h2C80);
    rdc("dev", 8'h07, 8'h2C);
    rdc("c2", 8'h0F, 8'h80);
    rdc("bsel", 8'h0E, 8'h03);
    rdc("frhi", 8'h16, 8'h5A);
    bus(1'b1, 8'h05, 8'h01);
    bus(1'b1, 8'h35, 8'h00);
    bus(1'b1, 8'h36, 8'h00);
    wt(1);
    chk("nostart", starts, 1);
    chk("nobusy", dma_busy, 0);
    results;
  end
endmodule
